// *** pkg/csp_pkg.sv ***
`default_nettype none
package csp_pkg;
  typedef enum logic [2:0] {
    CSP_UNDEF = 3'h0,
    CSP_DISC1 = 3'h1,
    CSP_DISC2 = 3'h2,
    CSP_DISC4 = 3'h3,
    CSP_CONT1 = 3'h4,
    CSP_CONT2 = 3'h5,
    CSP_CONT4 = 3'h6
  } csp_type_t;

  typedef enum logic [1:0] {
    CSP_VALID = 2'h0,
    CSP_SPECIAL = 2'h1,
    CSP_ERROR = 2'h2,
    CSP_NA = 2'h3
  } csp_state_t;

  // One logical output of a function block; value is unsigned Q16.16
  typedef struct packed {
    csp_state_t state;
    logic [31:0] logical_state_code;
    logic [31:0] value;
  } csp_sig_t;

  // Slot configuration word, bits 15:0 of the slot's first register
  typedef struct packed {
    logic [3:0] bitp;
    logic [3:0] bytep;
    logic [3:0] src;
    logic inv;
    csp_type_t typ;
  } csp_cfg_t;

  typedef enum logic [2:0] {
    CSP_S_IDLE = 3'h0,
    CSP_S_LOAD = 3'h1,
    CSP_S_DIV = 3'h2,
    CSP_S_PLACE = 3'h3,
    CSP_S_PUSH_LO = 3'h4,
    CSP_S_PUSH_HI = 3'h5
  } csp_fsm_t;

  // Register map (byte addresses)
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [4:0] R_CFG = 5'h00;
  localparam logic [4:0] R_RES = 5'h04;
  localparam logic [4:0] R_OFF = 5'h08;
  localparam logic [4:0] R_MAX = 5'h0C;
  localparam logic [4:0] R_MIN = 5'h10;
  localparam int CTRL_START_BIT = 0;

  // Reset values
  localparam logic [15:0] CFG_RST = 16'h1100;
  localparam logic [31:0] RES_RST = 32'h0001_0000;
  localparam logic [31:0] OFF_RST = 32'h0000_0000;
  localparam logic [31:0] MAX_RST = 32'h0001_0000;
  localparam logic [31:0] MIN_RST = 32'h0000_0000;
  localparam logic [31:0] V_ONE = 32'h0001_0000;
  localparam logic [31:0] V_HALF = 32'h0000_8000;
  localparam logic [5:0] DIV_STEPS = 6'h20;

  // Code values
  localparam logic [31:0] D2_ERR = 32'h2;
  localparam logic [31:0] D2_NA = 32'h3;
  localparam logic [31:0] D4_SPLIM = 32'hC;
  localparam logic [31:0] D4_SPADD = 32'h2;
  localparam logic [31:0] D4_SPSAT = 32'hD;
  localparam logic [31:0] D4_ERR = 32'hE;
  localparam logic [31:0] D4_NA = 32'hF;
  localparam logic [31:0] C1_MAX = 32'hFA;
  localparam logic [31:0] C1_SPLIM = 32'h3;
  localparam logic [31:0] C1_SPADD = 32'hFB;
  localparam logic [31:0] C1_SPSAT = 32'hFD;
  localparam logic [31:0] C1_ERR = 32'hFE;
  localparam logic [31:0] C1_NA = 32'hFF;
  localparam logic [31:0] C2_MAX = 32'hFAFF;
  localparam logic [31:0] C2_SPLIM = 32'h300;
  localparam logic [31:0] C2_SPADD = 32'hFB00;
  localparam logic [31:0] C2_SPSAT = 32'hFDFF;
  localparam logic [31:0] C2_ERLIM = 32'h100;
  localparam logic [31:0] C2_ERADD = 32'hFE00;
  localparam logic [31:0] C2_ERSAT = 32'hFEFF;
  localparam logic [31:0] C2_NA = 32'hFFFF;
  localparam logic [31:0] C4_MAX = 32'hFAFF_FFFF;
  localparam logic [31:0] C4_SPLIM = 32'h0300_0000;
  localparam logic [31:0] C4_SPADD = 32'hFB00_0000;
  localparam logic [31:0] C4_SPSAT = 32'hFDFF_FFFF;
  localparam logic [31:0] C4_ERLIM = 32'h0100_0000;
  localparam logic [31:0] C4_ERADD = 32'hFE00_0000;
  localparam logic [31:0] C4_ERSAT = 32'hFEFF_FFFF;
  localparam logic [31:0] C4_NA = 32'hFFFF_FFFF;
endpackage
`default_nettype wire

// *** verilog/csp_fifo.sv ***
`default_nettype none
module csp_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic push;
  logic pop;

  assign in_ready = (level != CW'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data = mem[rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule // csp_fifo
`default_nettype wire

// *** verilog/csp_packer.sv ***
// How it works
// R1: Each slot holds a type: undefined, 1/2/4-bit discrete, 1/2/4-byte continuous.
// R2: Each slot selects one function-block output or nothing; default unconnected.
// R3: Optional inversion per slot, off by default, applied before encoding.
// R4: Byte position 1..8, default 1; LSB byte of continuous codes.
// R5: Bit position 1..8, default 1; LSB of discrete code within its byte.
// R6: Software keeps discrete fields inside their byte, never straddling two.
// R7: Continuous resolution per bit, default 1, never zero; discrete ignores it.
// R8: Continuous offset, default 0; discrete ignores it.
// R9: Normalization max/min default 1 and 0; software keeps max above min.
// R10: Discrete valid: below 0.5 gives 0 else 1; 1-bit non-valid sends 1.
// R11: 2-bit: error sends 2; not available and special send 3.
// R12: 4-bit: special code+2 below 12 else 13; error 14; n/a 15.
// R13: 1-byte: valid 0..250; special code+251 below 3 else 253; 254; 255.
// R14: 2-byte: valid 0..64255; special code+64256 below 768 else 65023; n/a 65535.
// R15: 2-byte error: code+65024 below 256, otherwise 65279.
// R16: 4-byte ranges for valid, special, error and not-available codes as given.
// R17: Undefined type or unconnected source adds no bits to the frame.
// R18: Continuous: clamp to min/max, subtract offset, divide by resolution, bound.
//
// Our own choices: register access over AHB-Lite and the register addresses.
`default_nettype none
module csp_packer #(
  parameter int NSLOT = 5,
  parameter int NSRC = 15,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire csp_pkg::csp_sig_t src_sig [NSRC],
  input wire logic build_req,
  output logic busy,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [31:0] tx_data,
  output logic tx_last
);
  localparam int SW = $clog2(NSLOT+1);
  localparam int LW = $clog2(FIFO_DEPTH+1);

  csp_pkg::csp_cfg_t cfg [NSLOT];
  logic [31:0] res [NSLOT];
  logic [31:0] off [NSLOT];
  logic [31:0] vmax [NSLOT];
  logic [31:0] vmin [NSLOT];

  // Bus slave state
  logic wpend;
  logic rpend;
  logic [31:0] aaddr;
  logic wword;
  logic accept;
  logic wr_en;
  logic start_pulse;

  // Builder state
  csp_pkg::csp_fsm_t st;
  logic [SW-1:0] si;
  logic [63:0] frame;
  logic [31:0] quo;
  logic [32:0] rem;
  logic [5:0] dcnt;
  csp_pkg::csp_state_t cur_state;
  logic [31:0] cur_code;
  logic cur_bit;
  logic [15:0] frames;

  // FIFO hookup
  logic f_in_valid;
  logic f_in_ready;
  logic [32:0] f_in_data;
  logic f_out_valid;
  logic f_out_ready;
  logic [32:0] f_out_data;
  logic [LW-1:0] f_level;

  assign accept = hsel && htrans[1] && hready;
  assign wr_en = wpend && wword;

  // Slot index of a byte address: 1..NSLOT when mapped, 0 otherwise
  function automatic logic [SW-1:0] slot_of(input logic [31:0] a);
    logic [2:0] s;
    s = a[7:5];
    slot_of = '0;
    if (a[31:8] == 24'h0 && s != 3'h0 && int'(s) <= NSLOT) begin
      slot_of = SW'(s);
    end
  endfunction

  // Read decode
  function automatic logic [31:0] rd_word(input logic [31:0] a);
    logic [SW-1:0] s;
    s = slot_of(a);
    rd_word = 32'h0;
    if (a[31:8] == 24'h0 && a[7:0] == csp_pkg::A_STAT) begin
      rd_word = {frames, 8'h0, (8-LW)'(0), f_level} | {31'h0, busy};
      rd_word[1] = (st != csp_pkg::CSP_S_IDLE);
    end else if (s != '0) begin
      case (a[4:0])
        csp_pkg::R_CFG: rd_word = {16'h0, cfg[s-1]};
        csp_pkg::R_RES: rd_word = res[s-1];
        csp_pkg::R_OFF: rd_word = off[s-1];
        csp_pkg::R_MAX: rd_word = vmax[s-1];
        csp_pkg::R_MIN: rd_word = vmin[s-1];
        default: rd_word = 32'h0;
      endcase
    end
  endfunction

  // Signal state and value to CAN code
  function automatic logic [31:0] encode(input csp_pkg::csp_type_t t,
                                         input csp_pkg::csp_state_t s,
                                         input logic [31:0] c, input logic d,
                                         input logic [31:0] q);
    logic vld;
    vld = (s == csp_pkg::CSP_VALID);
    encode = {31'h0, d}; // R10
    case (t)
      csp_pkg::CSP_DISC1: begin
        if (!vld) encode = 32'h1; // R10
      end
      csp_pkg::CSP_DISC2: begin
        if (s == csp_pkg::CSP_ERROR) encode = csp_pkg::D2_ERR; // R11
        else if (!vld) encode = csp_pkg::D2_NA; // R11
      end
      csp_pkg::CSP_DISC4: begin
        case (s)
          csp_pkg::CSP_SPECIAL: encode = (c < csp_pkg::D4_SPLIM) ?
            c + csp_pkg::D4_SPADD : csp_pkg::D4_SPSAT; // R12
          csp_pkg::CSP_ERROR: encode = csp_pkg::D4_ERR; // R12
          csp_pkg::CSP_NA: encode = csp_pkg::D4_NA; // R12
          default: encode = {31'h0, d};
        endcase
      end
      csp_pkg::CSP_CONT1: begin
        case (s)
          csp_pkg::CSP_SPECIAL: encode = (c < csp_pkg::C1_SPLIM) ?
            c + csp_pkg::C1_SPADD : csp_pkg::C1_SPSAT; // R13
          csp_pkg::CSP_ERROR: encode = csp_pkg::C1_ERR; // R13
          csp_pkg::CSP_NA: encode = csp_pkg::C1_NA; // R13
          default: encode = (q > csp_pkg::C1_MAX) ? csp_pkg::C1_MAX : q; // R13 R18
        endcase
      end
      csp_pkg::CSP_CONT2: begin
        case (s)
          csp_pkg::CSP_SPECIAL: encode = (c < csp_pkg::C2_SPLIM) ?
            c + csp_pkg::C2_SPADD : csp_pkg::C2_SPSAT; // R14
          csp_pkg::CSP_ERROR: encode = (c < csp_pkg::C2_ERLIM) ?
            c + csp_pkg::C2_ERADD : csp_pkg::C2_ERSAT; // R15
          csp_pkg::CSP_NA: encode = csp_pkg::C2_NA; // R14
          default: encode = (q > csp_pkg::C2_MAX) ? csp_pkg::C2_MAX : q; // R14 R18
        endcase
      end
      csp_pkg::CSP_CONT4: begin
        case (s)
          csp_pkg::CSP_SPECIAL: encode = (c < csp_pkg::C4_SPLIM) ?
            c + csp_pkg::C4_SPADD : csp_pkg::C4_SPSAT; // R16
          csp_pkg::CSP_ERROR: encode = (c < csp_pkg::C4_ERLIM) ?
            c + csp_pkg::C4_ERADD : csp_pkg::C4_ERSAT; // R16
          csp_pkg::CSP_NA: encode = csp_pkg::C4_NA; // R16
          default: encode = (q > csp_pkg::C4_MAX) ? csp_pkg::C4_MAX : q; // R16 R18
        endcase
      end
      default: encode = 32'h0;
    endcase
  endfunction

  // Code width mask per type: discrete fields keep 1/2/4 bits, continuous types 1/2/4 bytes
  function automatic logic [31:0] width_mask(input csp_pkg::csp_type_t t);
    case (t)
      csp_pkg::CSP_DISC1: width_mask = 32'h1;
      csp_pkg::CSP_DISC2: width_mask = 32'h3;
      csp_pkg::CSP_DISC4: width_mask = 32'hF;
      csp_pkg::CSP_CONT1: width_mask = 32'hFF;
      csp_pkg::CSP_CONT2: width_mask = 32'hFFFF;
      csp_pkg::CSP_CONT4: width_mask = 32'hFFFF_FFFF;
      default: width_mask = 32'h0;
    endcase
  endfunction

  // AHB-Lite: writes complete with no wait, reads take one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wpend <= 1'b0;
      rpend <= 1'b0;
      wword <= 1'b0;
      aaddr <= 32'h0;
      hreadyout <= 1'b1;
      hrdata <= 32'h0;
      hresp <= 1'b0;
    end else begin
      wpend <= accept && hwrite;
      rpend <= accept && !hwrite;
      if (accept) begin
        aaddr <= haddr;
        wword <= (hsize == 3'h2) && (haddr[1:0] == 2'h0);
      end
      if (accept && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (rpend) begin
        hreadyout <= 1'b1;
        hrdata <= rd_word(aaddr);
      end
    end
  end

  assign start_pulse = wr_en && aaddr == {24'h0, csp_pkg::A_CTRL} &&
                       hwdata[csp_pkg::CTRL_START_BIT];

  // Per-slot configuration registers
  for (genvar i = 0; i < NSLOT; i++) begin : g_slot
    logic hit;
    assign hit = wr_en && slot_of(aaddr) == SW'(i + 1);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cfg[i] <= csp_pkg::CFG_RST; // R1 R2 R3 R4 R5
        res[i] <= csp_pkg::RES_RST; // R7
        off[i] <= csp_pkg::OFF_RST; // R8
        vmax[i] <= csp_pkg::MAX_RST; // R9
        vmin[i] <= csp_pkg::MIN_RST; // R9
      end else if (hit) begin
        case (aaddr[4:0])
          csp_pkg::R_CFG: begin
            if (hwdata[2:0] <= 3'h6) cfg[i].typ <= csp_pkg::csp_type_t'(hwdata[2:0]); // R1
            cfg[i].inv <= hwdata[3]; // R3
            if (int'(hwdata[7:4]) <= NSRC) cfg[i].src <= hwdata[7:4]; // R2
            if (hwdata[11:8] >= 4'h1 && hwdata[11:8] <= 4'h8) begin
              cfg[i].bytep <= hwdata[11:8]; // R4
            end
            if (hwdata[15:12] >= 4'h1 && hwdata[15:12] <= 4'h8) begin
              cfg[i].bitp <= hwdata[15:12]; // R5
            end
          end
          csp_pkg::R_RES: begin
            if (hwdata != 32'h0) res[i] <= hwdata; // R7
          end
          csp_pkg::R_OFF: off[i] <= hwdata; // R8
          csp_pkg::R_MAX: vmax[i] <= hwdata; // R9
          csp_pkg::R_MIN: vmin[i] <= hwdata; // R9
          default: ;
        endcase
      end
    end
  end

  // Frame builder: walks the slots, encodes each defined, connected one and ORs it into the frame
  logic [SW-1:0] cur_sel;
  csp_pkg::csp_sig_t pick;
  logic [31:0] vc;
  logic [31:0] vd;
  logic [31:0] num;
  logic [32:0] trial;
  logic [5:0] pos;
  logic is_cont;
  logic skip;

  always_comb begin
    cur_sel = SW'(si);
    pick = '0;
    for (int k = 0; k < NSRC; k++) begin
      if (int'(cfg[cur_sel].src) == k + 1) pick = src_sig[k]; // R2
    end
    is_cont = cfg[cur_sel].typ >= csp_pkg::CSP_CONT1;
    skip = (cfg[cur_sel].typ == csp_pkg::CSP_UNDEF) || (cfg[cur_sel].src == 4'h0); // R17
    // Clamp to the normalization window, then mirror when inverted
    vc = (pick.value < vmin[cur_sel]) ? vmin[cur_sel] :
         (pick.value > vmax[cur_sel]) ? vmax[cur_sel] : pick.value; // R18
    if (cfg[cur_sel].inv) vc = vmax[cur_sel] - vc + vmin[cur_sel]; // R3
    num = (vc > off[cur_sel]) ? vc - off[cur_sel] : 32'h0; // R8 R18
    vd = pick.value;
    if (cfg[cur_sel].inv) begin
      vd = (pick.value >= csp_pkg::V_ONE) ? 32'h0 : csp_pkg::V_ONE - pick.value; // R3
    end
    trial = {rem[31:0], quo[31]};
    pos = is_cont ? {cfg[cur_sel].bytep[2:0] - 3'h1, 3'h0} :
          {cfg[cur_sel].bytep[2:0] - 3'h1, cfg[cur_sel].bitp[2:0] - 3'h1}; // R4 R5
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= csp_pkg::CSP_S_IDLE;
      si <= '0;
      frame <= 64'h0;
      quo <= 32'h0;
      rem <= 33'h0;
      dcnt <= 6'h0;
      cur_state <= csp_pkg::CSP_VALID;
      cur_code <= 32'h0;
      cur_bit <= 1'b0;
      frames <= 16'h0;
      busy <= 1'b0;
    end else begin
      case (st)
        csp_pkg::CSP_S_IDLE: begin
          if (start_pulse || build_req) begin
            st <= csp_pkg::CSP_S_LOAD;
            si <= '0;
            frame <= 64'h0;
            busy <= 1'b1;
          end
        end
        csp_pkg::CSP_S_LOAD: begin
          cur_state <= pick.state;
          cur_code <= pick.logical_state_code;
          cur_bit <= (vd >= csp_pkg::V_HALF); // R10
          quo <= num;
          rem <= 33'h0;
          dcnt <= 6'h0;
          if (skip) begin
            st <= (int'(si) == NSLOT - 1) ? csp_pkg::CSP_S_PUSH_LO : csp_pkg::CSP_S_LOAD; // R17
            si <= si + 1'b1;
          end else if (is_cont && pick.state == csp_pkg::CSP_VALID) begin
            st <= csp_pkg::CSP_S_DIV; // R7 R18
          end else begin
            st <= csp_pkg::CSP_S_PLACE;
          end
        end
        csp_pkg::CSP_S_DIV: begin
          // Restoring division of the offset value by the resolution
          if (trial >= {1'b0, res[cur_sel]}) begin
            rem <= trial - {1'b0, res[cur_sel]}; // R18
            quo <= {quo[30:0], 1'b1};
          end else begin
            rem <= trial;
            quo <= {quo[30:0], 1'b0};
          end
          dcnt <= dcnt + 1'b1;
          if (dcnt == csp_pkg::DIV_STEPS - 6'h1) st <= csp_pkg::CSP_S_PLACE;
        end
        csp_pkg::CSP_S_PLACE: begin
          frame <= frame | ({32'h0, encode(cfg[cur_sel].typ, cur_state, cur_code,
                    cur_bit, quo) & width_mask(cfg[cur_sel].typ)} << pos); // R4 R5 R6
          st <= (int'(si) == NSLOT - 1) ? csp_pkg::CSP_S_PUSH_LO : csp_pkg::CSP_S_LOAD;
          si <= si + 1'b1;
        end
        csp_pkg::CSP_S_PUSH_LO: begin
          if (f_in_ready) st <= csp_pkg::CSP_S_PUSH_HI;
        end
        csp_pkg::CSP_S_PUSH_HI: begin
          if (f_in_ready) begin
            st <= csp_pkg::CSP_S_IDLE;
            frames <= frames + 1'b1;
            busy <= 1'b0;
          end
        end
        default: st <= csp_pkg::CSP_S_IDLE;
      endcase
    end
  end

  assign f_in_valid = (st == csp_pkg::CSP_S_PUSH_LO) || (st == csp_pkg::CSP_S_PUSH_HI);
  assign f_in_data = (st == csp_pkg::CSP_S_PUSH_HI) ? {1'b1, frame[63:32]} :
                     {1'b0, frame[31:0]};
  assign f_out_ready = !tx_valid || tx_ready;

  csp_fifo #(
    .WIDTH(33),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(hclk),
    .rst_n(hresetn),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data),
    .level(f_level)
  );

  // Registered transmit stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_valid <= 1'b0;
      tx_data <= 32'h0;
      tx_last <= 1'b0;
    end else if (f_out_ready) begin
      tx_valid <= f_out_valid;
      tx_data <= f_out_data[31:0];
      tx_last <= f_out_data[32];
    end
  end
endmodule // csp_packer
`default_nettype wire

// *** verilog/csp_packer_note_end.sv ***
`default_nettype none
`default_nettype wire

// *** sim/csp_packer_monitor.sv ***
`default_nettype none
module csp_packer_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic build_req,
  input wire logic busy,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [31:0] tx_data,
  input wire logic tx_last
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Expects the high word of a frame next
  logic hi_next;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_next <= 1'b0;
    end else if (tx_valid && tx_ready) begin
      hi_next <= !hi_next;
    end
  end
  sequence s_rd_taken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  a_read_wait: assert property (s_rd_taken |=> s_one_wait) else $error("read wait wrong");
  a_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write stalled");
  a_wait_short: assert property (!hreadyout |=> hreadyout) else $error("wait too long");
  a_rdata_hold: assert property (!$rose(hreadyout) |-> $stable(hrdata))
    else $error("hrdata moved");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
    && $stable(tx_last)) else $error("tx word dropped");
  a_frame_pair: assert property (tx_valid |-> tx_last == hi_next)
    else $error("frame word order");
  a_build_start: assert property (build_req && !busy |=> busy) else $error("no start");
  a_build_min: assert property ($rose(busy) |-> busy [*7])
    else $error("build too short");
endmodule // csp_packer_monitor
bind csp_packer csp_packer_monitor csp_packer_monitor_inst (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .hrdata, .build_req, .busy, .tx_valid, .tx_ready,
  .tx_data, .tx_last);
`default_nettype wire

// *** sim/csp_can_sink.sv ***
`default_nettype none
module csp_can_sink (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic tx_last,
  input wire logic stall,
  input wire logic slow,
  output logic tx_ready,
  output logic [63:0] frame,
  output logic [15:0] n_frames
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] lo;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_ready <= 1'b0;
      lo <= 32'h0;
      frame <= 64'h0;
      n_frames <= 16'h0;
    end else begin
      tx_ready <= !stall && !(slow && tx_ready);
      if (tx_valid && tx_ready && tx_last) begin
        frame <= {tx_data, lo};
        n_frames <= n_frames + 16'h1;
      end else if (tx_valid && tx_ready) begin
        lo <= tx_data;
      end
    end
  end
endmodule // csp_can_sink
`default_nettype wire

// *** sim/tb_csp_packer.sv ***
`default_nettype none
module tb_csp_packer;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hready, build_req, stall, slow;
  logic hreadyout, hresp, busy, tx_valid, tx_ready, tx_last;
  logic [31:0] haddr, hwdata, hrdata, tx_data, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, s;
  logic [63:0] frame;
  logic [15:0] n_frames, n0;
  csp_pkg::csp_sig_t src_sig [15];
  int n_mismatch = 0;
  int n_checks = 0;
  int n_built = 0;
  assign hready = hreadyout;
  csp_packer csp_packer_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .src_sig, .build_req, .busy, .tx_valid,
    .tx_ready, .tx_data, .tx_last);
  csp_can_sink csp_can_sink_inst (.hclk, .hresetn, .tx_valid, .tx_data, .tx_last, .stall,
    .slow, .tx_ready, .frame, .n_frames);
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] ra(input logic [2:0] sl, input logic [4:0] r);
    return {24'h0, sl, r};
  endfunction
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    cmp("reg", {32'h0, e}, {32'h0, rd});
  endtask
  // Second request cycle lands while busy and must not start another frame
  task automatic build(input logic [63:0] e);
    n0 = n_frames;
    n_built++;
    build_req <= 1'b1;
    repeat (2) @(posedge hclk);
    build_req <= 1'b0;
    while (n_frames === n0) @(posedge hclk);
    cmp("frame", e, frame);
  endtask
  task automatic nrm(input logic [2:0] sl, input logic [31:0] r, o, mx, mn);
    ahb(1'b1, ra(sl, csp_pkg::R_RES), r);
    ahb(1'b1, ra(sl, csp_pkg::R_OFF), o);
    ahb(1'b1, ra(sl, csp_pkg::R_MAX), mx);
    ahb(1'b1, ra(sl, csp_pkg::R_MIN), mn);
  endtask
  task automatic enc(input logic [2:0] sl, input logic [15:0] cfg, input logic [1:0] st,
      input logic [31:0] lsc, input logic [31:0] v, input logic [31:0] code);
    int sh;
    sh = (int'(cfg[11:8]) - 1) * 8 + ((cfg[2:0] > 3'h3) ? 0 : int'(cfg[15:12]) - 1);
    src_sig[cfg[7:4] - 4'h1] <= '{csp_pkg::csp_state_t'(st), lsc, v};
    ahb(1'b1, ra(sl, csp_pkg::R_CFG), {16'h0, cfg});
    build({32'h0, code} << sh);
    ahb(1'b1, ra(sl, csp_pkg::R_CFG), {16'h0, csp_pkg::CFG_RST});
    src_sig[cfg[7:4] - 4'h1] <= '{csp_pkg::CSP_NA, 32'h0, 32'h0};
  endtask
  initial begin
    repeat (30000) @(posedge hclk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    build_req = 1'b0;
    stall = 1'b0;
    slow = 1'b0;
    for (int i = 0; i < 15; i++) src_sig[i] = '{csp_pkg::CSP_NA, 32'h0, 32'h0};
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 1; i <= 5; i++) begin
      s = 3'(i);
      rdchk(ra(s, csp_pkg::R_CFG), {16'h0, csp_pkg::CFG_RST});
      rdchk(ra(s, csp_pkg::R_RES), csp_pkg::RES_RST);
      rdchk(ra(s, csp_pkg::R_OFF), csp_pkg::OFF_RST);
      rdchk(ra(s, csp_pkg::R_MAX), csp_pkg::MAX_RST);
      rdchk(ra(s, csp_pkg::R_MIN), csp_pkg::MIN_RST);
    end
    ahb(1'b1, ra(3'h1, csp_pkg::R_RES), 32'h0);
    rdchk(ra(3'h1, csp_pkg::R_RES), csp_pkg::RES_RST);
    ahb(1'b1, ra(3'h1, csp_pkg::R_CFG), 32'h1901);
    rdchk(ra(3'h1, csp_pkg::R_CFG), 32'h1101);
    ahb(1'b1, ra(3'h1, csp_pkg::R_CFG), {16'h0, csp_pkg::CFG_RST});
    rdchk(32'h14, 32'h0);
    build(64'h0);
    slow <= 1'b1;
    enc(3'h1, 16'h1111, 2'h0, 32'h0, 32'h8000, 32'h1);
    nrm(3'h2, 32'h20000, 32'hC000, 32'h10000, 32'h0);
    enc(3'h2, 16'h1129, 2'h0, 32'h0, 32'h4000, 32'h1);
    enc(3'h3, 16'h8831, 2'h2, 32'h7, 32'h0, 32'h1);
    enc(3'h4, 16'h7342, 2'h2, 32'h0, 32'h0, 32'h2);
    enc(3'h5, 16'h1152, 2'h1, 32'h9, 32'h0, 32'h3);
    enc(3'h1, 16'h1162, 2'h3, 32'h0, 32'h0, 32'h3);
    enc(3'h2, 16'h5273, 2'h1, 32'hA, 32'h0, 32'hC);
    enc(3'h3, 16'h5273, 2'h1, 32'hC, 32'h0, 32'hD);
    enc(3'h4, 16'h1183, 2'h2, 32'h0, 32'h0, 32'hE);
    enc(3'h5, 16'h1183, 2'h3, 32'h0, 32'h0, 32'hF);
    enc(3'h1, 16'h1494, 2'h1, 32'h1, 32'h0, 32'hFC);
    enc(3'h2, 16'h1494, 2'h1, 32'h3, 32'h0, 32'hFD);
    enc(3'h3, 16'h1494, 2'h2, 32'h0, 32'h0, 32'hFE);
    enc(3'h4, 16'h1494, 2'h3, 32'h0, 32'h0, 32'hFF);
    enc(3'h5, 16'h17A5, 2'h1, 32'h2FE, 32'h0, 32'hFDFE);
    enc(3'h1, 16'h17A5, 2'h1, 32'h300, 32'h0, 32'hFDFF);
    enc(3'h2, 16'h17A5, 2'h2, 32'h10, 32'h0, 32'hFE10);
    enc(3'h3, 16'h17A5, 2'h2, 32'h100, 32'h0, 32'hFEFF);
    enc(3'h4, 16'h17A5, 2'h3, 32'h0, 32'h0, 32'hFFFF);
    enc(3'h5, 16'h15B6, 2'h1, 32'h5, 32'h0, 32'hFB000005);
    enc(3'h1, 16'h15B6, 2'h1, 32'h3000000, 32'h0, 32'hFDFFFFFF);
    enc(3'h2, 16'h15B6, 2'h2, 32'h7, 32'h0, 32'hFE000007);
    enc(3'h3, 16'h15B6, 2'h3, 32'h0, 32'h0, 32'hFFFFFFFF);
    nrm(3'h1, 32'h200, 32'h0, 32'h10000, 32'h0);
    enc(3'h1, 16'h11C4, 2'h0, 32'h0, 32'h30000, 32'h80);
    nrm(3'h2, 32'h200, 32'h4000, 32'h10000, 32'h0);
    enc(3'h2, 16'h12C4, 2'h0, 32'h0, 32'hC000, 32'h40);
    nrm(3'h3, 32'h100, 32'h0, 32'h20000, 32'h0);
    enc(3'h3, 16'h11C4, 2'h0, 32'h0, 32'h20000, 32'hFA);
    nrm(3'h4, 32'h200, 32'h0, 32'h10000, 32'h8000);
    enc(3'h4, 16'h11C4, 2'h0, 32'h0, 32'h4000, 32'h40);
    enc(3'h4, 16'h11CC, 2'h0, 32'h0, 32'h4000, 32'h80);
    nrm(3'h5, 32'h1, 32'h0, 32'h20000, 32'h0);
    enc(3'h5, 16'h13C5, 2'h0, 32'h0, 32'h10000, 32'hFAFF);
    nrm(3'h1, 32'h1, 32'h0, 32'hFFFF0000, 32'h0);
    enc(3'h1, 16'h11C6, 2'h0, 32'h0, 32'hFFFF0000, 32'hFAFFFFFF);
    ahb(1'b1, ra(3'h2, csp_pkg::R_CFG), 32'h1103);
    build(64'h0);
    ahb(1'b1, ra(3'h2, csp_pkg::R_CFG), {16'h0, csp_pkg::CFG_RST});
    // Far side stalls: eight frames fill the buffer, the ninth holds the builder
    stall <= 1'b1;
    n0 = n_frames;
    for (int i = 0; i < 9; i++) begin
      build_req <= 1'b1;
      @(posedge hclk);
      build_req <= 1'b0;
      repeat (2) @(posedge hclk);
      while (busy === 1'b1 && i < 8) @(posedge hclk);
    end
    repeat (40) @(posedge hclk);
    cmp("busy", 64'h1, {63'h0, busy});
    stall <= 1'b0;
    n_built += 10;
    while (n_frames !== n0 + 16'h9) @(posedge hclk);
    cmp("frame", 64'h0, frame);
    ahb(1'b1, 32'(csp_pkg::A_CTRL), 32'h1);
    while (n_frames !== n0 + 16'hA) @(posedge hclk);
    cmp("frames", 64'(n_built), {48'h0, n_frames});
    complete_run();
  end
endmodule // tb_csp_packer
`default_nettype wire
